// File: hdl/rftx_cfg.svh
// Purpose: Offsets, field positions and reset values for the reader transmit-length block.
// Assumes: Included by bare name from the design and bench files.
// Notes: Definitions only.
`ifndef RFTX_CFG_SVH
`define RFTX_CFG_SVH

// ----------------------------------------------------------------------
// Device registers on the link
// ----------------------------------------------------------------------
`define RFTX_ADDR_FIFO_STAT 8'h1C
`define RFTX_ADDR_TX_UPPER 8'h1D
`define RFTX_ADDR_TX_LOWER 8'h1E
`define RFTX_LEN_RESET 8'h00
`define RFTX_LEVEL_MAX 7'h7F
`define RFTX_FULL_BYTE_BITS 4'h8

// ----------------------------------------------------------------------
// Host registers, Avalon word index
// ----------------------------------------------------------------------
`define RFTX_HREG_LEN 3'h0
`define RFTX_HREG_CMD 3'h1
`define RFTX_HREG_CTRL 3'h2
`define RFTX_HREG_STATUS 3'h3
`define RFTX_HREG_IRQ_STAT 3'h4
`define RFTX_HREG_IRQ_MASK 3'h5
`define RFTX_CMD_SEND_LEN 0
`define RFTX_CMD_READ_STAT 1
`define RFTX_CTRL_CHIP_EN 0
`define RFTX_IRQ_LEN_DONE 0
`define RFTX_IRQ_STAT_DONE 1
`define RFTX_IRQ_OVERFLOW 2
`define RFTX_IRQ_RESET 3'h0
`define RFTX_LEN_FLAG_BIT 15
`define RFTX_OVF_BIT 7

`endif

// File: hdl/rftx_pkg.sv
// Purpose: Types shared by both ends of the reader transmit-length block.
// Assumes: Constants live in rftx_cfg.svh.
// Notes: Nothing here is imported; users write rftx_pkg::name.
package rftx_pkg;

    typedef enum logic [1:0] {TX_IDLE, TX_BYTES, TX_PART, TX_EOF} rftx_tx_state_t;

    typedef enum logic [1:0] {H_IDLE, H_WR_HI, H_WR_LO, H_RD} rftx_host_state_t;

endpackage

// File: hdl/rftx_if.sv
// Purpose: Register link between the host controller and the reader device.
// Assumes: Both ends run on the same clock.
// Notes: A request is held until the one-cycle acknowledge.
`timescale 1ns/10ps
interface rftx_if;
    logic chip_en;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;

    modport dev
    (
        input chip_en, req, we, addr, wdata,
        output rdata, ack
    );

    modport host
    (
        output chip_en, req, we, addr, wdata,
        input rdata, ack
    );
endinterface

// File: hdl/rftx_lenreg.sv
// Purpose: One transmit-length register with write and two kinds of clear.
// Assumes: Same clock and reset as the instantiating end.
// Notes: The disable clear beats a write; a write beats the end-of-frame clear.
`timescale 1ns/10ps
module rftx_lenreg #(
    parameter int W = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic hold_clr,
    input wire logic we,
    input wire logic [W-1:0] wdata,
    input wire logic eof_clr,
    // Value
    output logic [W-1:0] q
);
    logic [W-1:0] d;

    always_comb
    begin
        if (hold_clr)
            d = '0;
        else if (we)
            d = wdata;
        else if (eof_clr)
            d = '0;
        else
            d = q;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            q <= '0;
        else
            q <= d;
    end
endmodule

// File: hdl/rftx_dev.sv
// Purpose: Reader device end: FIFO fill status, transmit-length registers and transmit sequencer.
// Assumes: Host keeps a link request steady until ack; FIFO storage lives outside.
// Notes: Link answers one cycle after a request is taken.
//
// Chosen here: the rftx_if register link to the host.
`timescale 1ns/10ps
`include "rftx_cfg.svh"

module rftx_dev
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Link to the host
    rftx_if.dev link,
    // FIFO traffic from the data path
    input wire logic fifo_wr,
    input wire logic fifo_rd,
    // Transmit control and output
    input wire logic tx_start,
    output logic tx_pop,
    output logic [3:0] tx_nbits,
    output logic tx_eof,
    output logic tx_busy,
    output logic [6:0] fifo_level
);

    // ----------------------------------------------------------------------
    // Register link
    // ----------------------------------------------------------------------
    logic ack_q;
    logic ack_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic take;
    logic wr_upper;
    logic wr_lower;
    logic hold_clr;
    logic eof_clr;
    logic [7:0] upper_q;
    logic [7:0] lower_q;
    logic ovf_q;
    logic ovf_d;
    logic [6:0] level_q;
    logic [6:0] level_d;

    assign take = link.req && !ack_q;
    assign wr_upper = take && link.we && (link.addr == `RFTX_ADDR_TX_UPPER);
    assign wr_lower = take && link.we && (link.addr == `RFTX_ADDR_TX_LOWER);
    assign hold_clr = !link.chip_en;

    always_comb
    begin
        ack_d = take;
        rdata_d = rdata_q;
        if (take && !link.we)
        begin
            case (link.addr)
                `RFTX_ADDR_FIFO_STAT: rdata_d = {ovf_q, level_q};
                `RFTX_ADDR_TX_UPPER: rdata_d = upper_q;
                `RFTX_ADDR_TX_LOWER: rdata_d = lower_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_q <= 1'b0;
            rdata_q <= 8'h00;
        end
        else
        begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    assign link.ack = ack_q;
    assign link.rdata = rdata_q;

    // ----------------------------------------------------------------------
    // Transmit-length registers
    // ----------------------------------------------------------------------
    // Upper holds count[11:4], lower holds count[3:0], bit count and flag.
    rftx_lenreg #(.W(8)) u_upper
    (
        .clk(clk),
        .rstn(rstn),
        .hold_clr(hold_clr),
        .we(wr_upper),
        .wdata(link.wdata),
        .eof_clr(eof_clr),
        .q(upper_q)
    );

    rftx_lenreg #(.W(8)) u_lower
    (
        .clk(clk),
        .rstn(rstn),
        .hold_clr(hold_clr),
        .we(wr_lower),
        .wdata(link.wdata),
        .eof_clr(eof_clr),
        .q(lower_q)
    );

    // ----------------------------------------------------------------------
    // Transmit sequencer
    // ----------------------------------------------------------------------
    rftx_pkg::rftx_tx_state_t state_q;
    rftx_pkg::rftx_tx_state_t state_d;
    logic [11:0] remain_q;
    logic [11:0] remain_d;
    logic [2:0] part_q;
    logic [2:0] part_d;
    logic flag_q;
    logic flag_d;
    logic pop_d;
    logic [3:0] nbits_d;
    logic eof_d;
    logic have_byte;

    assign have_byte = (level_q != 7'h00);
    assign eof_clr = (state_q == rftx_pkg::TX_EOF);

    always_comb
    begin
        state_d = state_q;
        remain_d = remain_q;
        part_d = part_q;
        flag_d = flag_q;
        pop_d = 1'b0;
        nbits_d = tx_nbits;
        eof_d = 1'b0;
        case (state_q)
            rftx_pkg::TX_IDLE:
            begin
                if (tx_start)
                begin
                    // The count is latched so host writes during a frame do not disturb it.
                    remain_d = {upper_q, lower_q[7:4]};
                    part_d = lower_q[3:1];
                    flag_d = lower_q[0];
                    state_d = rftx_pkg::TX_BYTES;
                end
            end
            rftx_pkg::TX_BYTES:
            begin
                if (remain_q == 12'h000)
                    state_d = flag_q ? rftx_pkg::TX_PART : rftx_pkg::TX_EOF;
                else if (have_byte)
                begin
                    pop_d = 1'b1;
                    nbits_d = `RFTX_FULL_BYTE_BITS;
                    remain_d = remain_q - 12'h001;
                end
            end
            rftx_pkg::TX_PART:
            begin
                if (have_byte)
                begin
                    pop_d = 1'b1;
                    nbits_d = {1'b0, part_q};
                    state_d = rftx_pkg::TX_EOF;
                end
            end
            rftx_pkg::TX_EOF:
            begin
                eof_d = 1'b1;
                state_d = rftx_pkg::TX_IDLE;
            end
            default:
            begin
                state_d = rftx_pkg::TX_IDLE;
            end
        endcase
        // Dropping chip enable aborts the frame without an end-of-frame pulse.
        if (hold_clr)
        begin
            state_d = rftx_pkg::TX_IDLE;
            pop_d = 1'b0;
            eof_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= rftx_pkg::TX_IDLE;
            remain_q <= 12'h000;
            part_q <= 3'h0;
            flag_q <= 1'b0;
            tx_pop <= 1'b0;
            tx_nbits <= 4'h0;
            tx_eof <= 1'b0;
            tx_busy <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            remain_q <= remain_d;
            part_q <= part_d;
            flag_q <= flag_d;
            tx_pop <= pop_d;
            tx_nbits <= nbits_d;
            tx_eof <= eof_d;
            tx_busy <= (state_d != rftx_pkg::TX_IDLE);
        end
    end

    // ----------------------------------------------------------------------
    // FIFO fill level and overflow
    // ----------------------------------------------------------------------
    logic inc;
    logic dec;

    // The data path may only read out while no frame is being sent.
    assign inc = fifo_wr && link.chip_en;
    assign dec = pop_d || (fifo_rd && !tx_busy && have_byte);

    always_comb
    begin
        level_d = level_q;
        ovf_d = ovf_q;
        if (hold_clr)
        begin
            level_d = 7'h00;
            ovf_d = 1'b0;
        end
        else if (inc && !dec && (level_q == `RFTX_LEVEL_MAX))
            ovf_d = 1'b1;
        else if (inc && !dec)
            level_d = level_q + 7'h01;
        else if (dec && !inc)
            level_d = level_q - 7'h01;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            level_q <= 7'h00;
            ovf_q <= 1'b0;
            fifo_level <= 7'h00;
        end
        else
        begin
            level_q <= level_d;
            ovf_q <= ovf_d;
            fifo_level <= level_d;
        end
    end
endmodule

// File: hdl/rftx_host.sv
// Purpose: Host controller end: Avalon-MM registers drive length writes and status reads over the link.
// Assumes: Avalon word addressing; master holds a request until waitrequest is low.
// Notes: Commands arriving while the link is busy are dropped.
`timescale 1ns/10ps
`include "rftx_cfg.svh"
module rftx_host
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [2:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Interrupt
    output logic irq,
    // Link to the device
    rftx_if.host link
);

    // ----------------------------------------------------------------------
    // Avalon slave
    // ----------------------------------------------------------------------
    logic wait_d;
    logic [31:0] rdata_d;
    logic commit;
    logic [15:0] len_q;
    logic [15:0] len_d;
    logic en_q;
    logic en_d;
    logic [7:0] stat_q;
    logic [7:0] stat_d;
    logic [2:0] irqs_q;
    logic [2:0] irqs_d;
    logic [2:0] mask_q;
    logic [2:0] mask_d;
    logic [2:0] irq_set;
    logic cmd_len;
    logic cmd_rd;
    rftx_pkg::rftx_host_state_t state_q;
    rftx_pkg::rftx_host_state_t state_d;
    logic rd_pend_q;
    logic rd_pend_d;

    // A write takes effect at the edge where waitrequest is seen low.
    assign commit = write && !waitrequest;
    assign cmd_len = commit && byteenable[0] && (address == `RFTX_HREG_CMD) && writedata[`RFTX_CMD_SEND_LEN];
    assign cmd_rd = commit && byteenable[0] && (address == `RFTX_HREG_CMD) && writedata[`RFTX_CMD_READ_STAT];

    always_comb
    begin
        wait_d = !((read || write) && waitrequest);
        rdata_d = readdata;
        if ((read || write) && waitrequest)
        begin
            case (address)
                `RFTX_HREG_LEN: rdata_d = {16'h0000, len_q};
                `RFTX_HREG_CTRL: rdata_d = {31'h0, en_q};
                `RFTX_HREG_STATUS: rdata_d = {23'h0, (state_q != rftx_pkg::H_IDLE), stat_q};
                `RFTX_HREG_IRQ_STAT: rdata_d = {29'h0, irqs_q};
                `RFTX_HREG_IRQ_MASK: rdata_d = {29'h0, mask_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        len_d = len_q;
        en_d = en_q;
        mask_d = mask_q;
        if (commit && (address == `RFTX_HREG_LEN) && byteenable[0])
            len_d[7:0] = writedata[7:0];
        if (commit && (address == `RFTX_HREG_LEN) && byteenable[1])
            len_d[15:8] = writedata[15:8];
        if (commit && (address == `RFTX_HREG_CTRL) && byteenable[0])
            en_d = writedata[`RFTX_CTRL_CHIP_EN];
        if (commit && (address == `RFTX_HREG_IRQ_MASK) && byteenable[0])
            mask_d = writedata[2:0];
        // A new event beats a write-one clear in the same cycle.
        irqs_d = irqs_q;
        if (commit && (address == `RFTX_HREG_IRQ_STAT) && byteenable[0])
            irqs_d = irqs_q & ~writedata[2:0];
        irqs_d = irqs_d | irq_set;
    end

    // ----------------------------------------------------------------------
    // Link sequencer
    // ----------------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        rd_pend_d = rd_pend_q;
        stat_d = stat_q;
        irq_set = 3'h0;
        case (state_q)
            rftx_pkg::H_IDLE:
            begin
                if (cmd_len)
                begin
                    state_d = rftx_pkg::H_WR_HI;
                    rd_pend_d = cmd_rd;
                end
                else if (cmd_rd)
                    state_d = rftx_pkg::H_RD;
            end
            rftx_pkg::H_WR_HI:
            begin
                if (link.ack)
                    state_d = rftx_pkg::H_WR_LO;
            end
            rftx_pkg::H_WR_LO:
            begin
                if (link.ack)
                begin
                    irq_set[`RFTX_IRQ_LEN_DONE] = 1'b1;
                    state_d = rd_pend_q ? rftx_pkg::H_RD : rftx_pkg::H_IDLE;
                    rd_pend_d = 1'b0;
                end
            end
            rftx_pkg::H_RD:
            begin
                if (link.ack)
                begin
                    stat_d = link.rdata;
                    irq_set[`RFTX_IRQ_STAT_DONE] = 1'b1;
                    irq_set[`RFTX_IRQ_OVERFLOW] = link.rdata[`RFTX_OVF_BIT];
                    state_d = rftx_pkg::H_IDLE;
                end
            end
            default:
            begin
                state_d = rftx_pkg::H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
            len_q <= 16'h0000;
            en_q <= 1'b0;
            mask_q <= `RFTX_IRQ_RESET;
            irqs_q <= `RFTX_IRQ_RESET;
            irq <= 1'b0;
            stat_q <= 8'h00;
            state_q <= rftx_pkg::H_IDLE;
            rd_pend_q <= 1'b0;
            link.chip_en <= 1'b0;
            link.req <= 1'b0;
            link.we <= 1'b0;
            link.addr <= 8'h00;
            link.wdata <= 8'h00;
        end
        else
        begin
            waitrequest <= wait_d;
            readdata <= rdata_d;
            len_q <= len_d;
            en_q <= en_d;
            mask_q <= mask_d;
            irqs_q <= irqs_d;
            irq <= |(irqs_d & mask_d);
            stat_q <= stat_d;
            state_q <= state_d;
            rd_pend_q <= rd_pend_d;
            link.chip_en <= en_d;
            link.req <= (state_d != rftx_pkg::H_IDLE);
            link.we <= (state_d == rftx_pkg::H_WR_HI) || (state_d == rftx_pkg::H_WR_LO);
            case (state_d)
                rftx_pkg::H_WR_HI: link.addr <= `RFTX_ADDR_TX_UPPER;
                rftx_pkg::H_WR_LO: link.addr <= `RFTX_ADDR_TX_LOWER;
                default: link.addr <= `RFTX_ADDR_FIFO_STAT;
            endcase
            // Upper byte is count[11:4]; lower is count[3:0], bit count, flag.
            if (state_d == rftx_pkg::H_WR_HI)
                link.wdata <= len_d[11:4];
            else
                link.wdata <= {len_d[3:0], len_d[14:12], len_d[`RFTX_LEN_FLAG_BIT]};
        end
    end
endmodule

// File: bench/rftx_link_assertions.sv
// Purpose: Concurrent checks on the register link between host and reader device.
// Assumes: Signals come straight from the link interface; one clock domain.
// Notes: Instantiated beside the interface in the bench top.
`timescale 1ns/10ps
`include "rftx_cfg.svh"
module rftx_link_assertions
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Link signals
    input wire logic chip_en,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack
);
    // ------------------------------------------------------------------
    // Link handshake
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    chk_ack_after_take: assert property (req && !ack |=> ack)
        else $error("link request not answered in the next cycle");
    chk_ack_one_cycle: assert property (ack |=> !ack)
        else $error("link acknowledge longer than one cycle");
    chk_req_held: assert property (req && !ack |=> req && $stable(we) && $stable(addr) && $stable(wdata))
        else $error("link request changed before acknowledge");
    chk_ack_needs_req: assert property (ack |-> req && $past(req))
        else $error("link acknowledge without a request");

    // ------------------------------------------------------------------
    // Register contents
    // ------------------------------------------------------------------
    // The lower length byte always follows the upper one; a frame started between the two writes still latches a half-written count.
    chk_hi_then_lo: assert property (ack && we && addr == `RFTX_ADDR_TX_UPPER
        |=> ##[0:2] (req && we && addr == `RFTX_ADDR_TX_LOWER))
        else $error("lower length byte did not follow upper byte");
    chk_off_reads_zero: assert property ((!chip_en [*2] ##0 (req && !ack && !we &&
        addr inside {`RFTX_ADDR_FIFO_STAT, `RFTX_ADDR_TX_UPPER, `RFTX_ADDR_TX_LOWER})) |=> rdata == 8'h00)
        else $error("register not cleared while device disabled");
    chk_rdata_holds: assert property (!(req && !ack && !we) |=> $stable(rdata))
        else $error("read data changed without a read");
    chk_only_len_writes: assert property (req && we |-> addr inside {`RFTX_ADDR_TX_UPPER, `RFTX_ADDR_TX_LOWER})
        else $error("write to a register other than the length pair");
endmodule

// File: bench/rf_reader_fifo_status_tx_length_tb.sv
// Purpose: Self-checking bench joining the host controller and reader device ends.
// Assumes: Avalon master holds each request until waitrequest is sampled low.
// Notes: FIFO pushes are fed during transmit so pops never starve for long.
`timescale 1ns/10ps
`include "rftx_cfg.svh"
`define CHK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
    $display("MISMATCH t=%0t %s", $time, msg); end end
module rf_reader_fifo_status_tx_length_tb;
    logic clk, rstn, read, write, irq, waitrequest, fifo_wr, fifo_rd, tx_start, tx_pop, tx_eof, tx_busy;
    logic [2:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable, tx_nbits;
    logic [6:0] fifo_level;
    int mismatches = 0;
    int tests_run = 0;

    // ------------------------------------------------------------------
    // Design and checker
    // ------------------------------------------------------------------
    rftx_if link_if();
    rftx_host u_rftx_host(.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .irq(irq), .link(link_if));
    rftx_dev u_rftx_dev(.clk(clk), .rstn(rstn), .link(link_if), .fifo_wr(fifo_wr), .fifo_rd(fifo_rd),
        .tx_start(tx_start), .tx_pop(tx_pop), .tx_nbits(tx_nbits), .tx_eof(tx_eof), .tx_busy(tx_busy),
        .fifo_level(fifo_level));
    rftx_link_assertions u_rftx_link_assertions(.clk(clk), .rstn(rstn), .chip_en(link_if.chip_en),
        .req(link_if.req), .we(link_if.we), .addr(link_if.addr), .wdata(link_if.wdata),
        .rdata(link_if.rdata), .ack(link_if.ack));

    always #5 clk = ~clk;

    // ------------------------------------------------------------------
    // Bus and sequence tasks
    // ------------------------------------------------------------------
    task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        write <= w;
        read <= !w;
        writedata <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 100);
        q = readdata;
        if (waitrequest !== 1'b0)
        begin
            mismatches++;
            $display("MISMATCH t=%0t bus wait timed out", $time);
        end
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic wait_irq(input int b);
        logic [31:0] q;
        q = '0;
        for (int i = 0; i < 30 && q[b] !== 1'b1; i++) av(1'b0, `RFTX_HREG_IRQ_STAT, 32'h0, q);
        `CHK(q[b], 1'b1, "completion flag not raised")
        av(1'b1, `RFTX_HREG_IRQ_STAT, 32'h1 << b, q);
    endtask

    task automatic get_status(output logic [7:0] s);
        logic [31:0] q;
        av(1'b1, `RFTX_HREG_CMD, 32'h2, q);
        wait_irq(`RFTX_IRQ_STAT_DONE);
        av(1'b0, `RFTX_HREG_STATUS, 32'h0, q);
        s = q[7:0];
    endtask

    task automatic send_len(input logic [15:0] v);
        logic [31:0] q;
        av(1'b1, `RFTX_HREG_LEN, {16'h0, v}, q);
        av(1'b1, `RFTX_HREG_CMD, 32'h1, q);
        wait_irq(`RFTX_IRQ_LEN_DONE);
    endtask

    task automatic push(input int n);
        @(posedge clk);
        fifo_wr <= 1'b1;
        repeat (n) @(posedge clk);
        fifo_wr <= 1'b0;
    endtask

    // Keeps the FIFO topped up a few bytes deep so long frames finish quickly.
    task automatic run_tx(input int nfull, input int part, input logic [3:0] bits);
        int npop;
        logic done;
        npop = 0;
        done = 1'b0;
        @(posedge clk);
        tx_start <= 1'b1;
        @(posedge clk);
        tx_start <= 1'b0;
        for (int i = 0; i < 3000 && !done; i++)
        begin
            @(posedge clk);
            if (tx_pop === 1'b1)
            begin
                npop++;
                `CHK(tx_nbits, (npop > nfull) ? bits : `RFTX_FULL_BYTE_BITS, "popped byte width")
            end
            done = (tx_eof === 1'b1);
            `CHK(tx_busy, !done, "busy level during frame")
            // Topping up ends with the frame, so the push line is released by this one assignment.
            fifo_wr <= !done && (i < 2999) && (fifo_level < 7'h04);
        end
        `CHK(done, 1'b1, "frame never ended")
        `CHK(npop, nfull + part, "popped byte count")
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_level();
        logic [31:0] q;
        logic [7:0] s;
        av(1'b1, `RFTX_HREG_CTRL, 32'h1, q);
        push(5);
        @(posedge clk);
        fifo_rd <= 1'b1;
        repeat (2) @(posedge clk);
        fifo_rd <= 1'b0;
        get_status(s);
        `CHK(s, 8'h03, "fill count after five in, two out")
        `CHK(fifo_level, 7'h03, "fill level port")
        `CHK(irq, 1'b0, "masked event raised interrupt")
        av(1'b0, 3'h7, 32'h0, q);
        `CHK(q, 32'h0, "unmapped host read")
        $display("test_level done");
    endtask

    task automatic test_tx();
        send_len({1'b1, 3'h5, 12'h111});
        run_tx(273, 1, 4'h5);
        run_tx(0, 0, 4'h0);
        send_len({1'b0, 3'h6, 12'h002});
        run_tx(2, 0, 4'h0);
        $display("test_tx done");
    endtask

    task automatic test_disable();
        logic [31:0] q;
        logic [7:0] s;
        send_len(16'h0004);
        av(1'b1, `RFTX_HREG_CTRL, 32'h0, q);
        get_status(s);
        `CHK(s, 8'h00, "status while disabled")
        av(1'b1, `RFTX_HREG_CTRL, 32'h1, q);
        run_tx(0, 0, 4'h0);
        $display("test_disable done");
    endtask

    task automatic test_overflow();
        logic [31:0] q;
        logic [7:0] s;
        av(1'b1, `RFTX_HREG_IRQ_MASK, 32'h4, q);
        push(130);
        get_status(s);
        `CHK(s, 8'hFF, "overflow with full count")
        `CHK(irq, 1'b1, "overflow interrupt missing")
        av(1'b1, `RFTX_HREG_IRQ_STAT, 32'h4, q);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0, "interrupt not cleared")
        $display("test_overflow done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        rstn = 1'b0;
        address = 3'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'hF;
        fifo_wr = 1'b0;
        fifo_rd = 1'b0;
        tx_start = 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        test_level();
        test_tx();
        test_disable();
        test_overflow();
        stop_test();
    end

    // The longest frame is a few hundred bytes, so this span leaves ample margin.
    initial
    begin
        #400000;
        mismatches++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        stop_test();
    end
endmodule
